// File: inc/sbe_pkg.sv
/*
 * constants and carriers of the bus control block.
 * assumes one bus clock and axi4-lite with 8-bit byte addresses.
 */
package sbe_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0] ADDR_CFG = 8'h00, ADDR_CTRL = 8'h04, ADDR_STATUS = 8'h08, ADDR_LIMIT0 = 8'h0c,
        ADDR_LIMIT1 = 8'h10;

    // control register fields
    localparam int CTRL_STALL = 0, CTRL_MONSEL0 = 1, CTRL_MONSEL1 = 2;
    localparam int CTRL_WIDTH = 3;
    localparam logic [2:0] CTRL_RST = 3'h0;

    // status register fields
    localparam int ST_INTERNAL = 0, ST_FAULT = 1, ST_REINIT = 2, ST_STALL = 3, ST_PRIO = 4,
        ST_ROTID = 5, ST_CFGVALID = 7, ST_INFLIGHT = 8, ST_REACHED = 12;

    // counter limits
    localparam int LIMIT_WIDTH = 16;
    localparam logic [15:0] LIMIT_RST = 16'hffff;

    // strobe hold, in clocks
    localparam logic [3:0] FAULT_HOLD_CYC = 4'h3;
    localparam logic [3:0] REINIT_HOLD_CYC = 4'h3;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } sbe_axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } sbe_axi_rsp_s;

    // power-on options
    typedef struct packed {
        logic [1:0] agentId;
        logic reinitObserve;
        logic reinitDrive;
        logic faultAny;
        logic faultInitiator;
        logic faultInternal;
        logic faultEn;
    } sbe_strap_s;

    // open-drain pad: oe high pulls low
    typedef struct packed {
        logic o;
        logic oe;
    } sbe_pad_s;

    typedef struct packed {
        logic [1:0] o;
        logic [1:0] oe;
    } sbe_pad2_s;

endpackage

// File: core/sbe_event_counter.sv
/*
 * saturating event counter with a reached flag.
 * assumes a registered clear pulse.
 */
`timescale 1ns/1ps
module sbe_event_counter (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic clear,
    input wire logic event_i,
    input wire logic [15:0] limit,
    // result
    output logic reached
);

    typedef struct packed {
        logic [15:0] count;
        logic reached;
    } sbe_cnt_state_s;

    sbe_cnt_state_s s_r;
    sbe_cnt_state_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (clear) begin
            s_nxt.count = 16'h0000;
        end else if (event_i && s_r.count != 16'hffff) begin
            s_nxt.count = s_r.count + 16'h0001;
        end
        s_nxt.reached = (s_nxt.count >= limit);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign reached = s_r.reached;

endmodule

// File: core/sbe_bus_ctrl.sv
/*
 * fault, reinit, stall and priority pins of one bus agent, with an axi4-lite slave.
 * assumes all pins are synchronous to clk, open-drain pads resolved outside.
 */
// Notes on behaviour
// - any agent may flag an unrecoverable error that broke no protocol
// - the processor ignores the fault line driven by others
// - fault line driving is a configuration choice; disabled means never driven
// - internal errors drive the fault line alongside the internal fault pin
// - a transaction initiator drives the fault line after seeing an error
// - permissive option: any agent seeing a transaction error drives it
// - reinit driver enabled agents assert reinit on unreliable bus conditions
// - observed reinit returns bus state machines to idle, drops data in transit
// - observed reinit restores the rotating id and drops count information
// - reinit leaves cache contents untouched, clears only bus-side state
// - an agent unable to accept transactions asserts block-next-request
// - while a stall is seen, no new transaction starts
// - block-next-request is wired-or, driven and sampled on fixed edges
// - breakpoint status outputs follow the breakpoints
// - monitor outputs follow breakpoints and performance counters
// - priority request seen: stop new requests except locked ones
// - all outputs driven and inputs captured on the rising clock edge
// - power-on options captured from address lines at reset release
`timescale 1ns/1ps
module sbe_bus_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register bus
    input wire sbe_pkg::sbe_axi_req_s axiReq,
    output sbe_pkg::sbe_axi_rsp_s axiRsp,
    // bus reset and power-on options
    input wire logic busResetN,
    input wire sbe_pkg::sbe_strap_s addrLines,
    // bus fault line
    input wire logic busFaultNIn,
    output sbe_pkg::sbe_pad_s busFaultNPad,
    // bus reinit line
    input wire logic busReinitNIn,
    output sbe_pkg::sbe_pad_s busReinitNPad,
    // stall line
    input wire logic blockNextRequestNIn,
    output sbe_pkg::sbe_pad_s blockNextRequestNPad,
    // priority request
    input wire logic priorityBusRequestNIn,
    // internal fault and breakpoint pins
    output sbe_pkg::sbe_pad_s internalFaultNPad,
    output sbe_pkg::sbe_pad2_s breakStatusNPad,
    output sbe_pkg::sbe_pad2_s breakMonitorNPad,
    // core events
    input wire logic internalErr,
    input wire logic initiatorErr,
    input wire logic observedErr,
    input wire logic unreliable,
    input wire logic notReady,
    input wire logic [1:0] breakHit,
    input wire logic [1:0] perfEvent,
    // request path
    input wire logic reqPending,
    input wire logic reqLocked,
    input wire logic arbRotate,
    input wire logic txnStart,
    input wire logic txnDone,
    output logic reqGrant,
    output logic busFlush,
    output logic [1:0] rotId
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        sbe_pkg::sbe_axi_rsp_s axi;
        logic awHeld;
        logic [7:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic rstPrev;
        logic cfgValid;
        sbe_pkg::sbe_strap_s strap;
        logic [2:0] ctrl;
        logic [15:0] limit0;
        logic [15:0] limit1;
        logic clr0;
        logic clr1;
        logic internalSeen;
        logic faultSent;
        logic reinitSeen;
        logic phase;
        logic stallSeen;
        logic prioSeen;
        logic [3:0] faultCnt;
        logic [3:0] reinitCnt;
        logic [1:0] rotId;
        logic [3:0] inFlight;
        sbe_pkg::sbe_pad_s faultPad;
        sbe_pkg::sbe_pad_s reinitPad;
        sbe_pkg::sbe_pad_s stallPad;
        sbe_pkg::sbe_pad_s intFaultPad;
        sbe_pkg::sbe_pad2_s breakPad;
        sbe_pkg::sbe_pad2_s monitorPad;
        logic reqGrant;
        logic busFlush;
    } sbe_core_state_s;

    sbe_core_state_s s_r;
    sbe_core_state_s s_nxt;
    logic [1:0] reached;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic addrOk(input logic [7:0] a);
        addrOk = (a == sbe_pkg::ADDR_CFG) || (a == sbe_pkg::ADDR_CTRL) ||
            (a == sbe_pkg::ADDR_STATUS) || (a == sbe_pkg::ADDR_LIMIT0) ||
            (a == sbe_pkg::ADDR_LIMIT1);
    endfunction

    function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] dat,
        input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                m[i*8 +: 8] = dat[i*8 +: 8];
            end
        end
        mergeBytes = m;
    endfunction

    function automatic logic [31:0] statusWord(input sbe_core_state_s st, input logic [1:0] rch);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[sbe_pkg::ST_INTERNAL] = st.internalSeen;
        w[sbe_pkg::ST_FAULT] = st.faultSent;
        w[sbe_pkg::ST_REINIT] = st.reinitSeen;
        w[sbe_pkg::ST_STALL] = st.stallSeen;
        w[sbe_pkg::ST_PRIO] = st.prioSeen;
        w[sbe_pkg::ST_ROTID +: 2] = st.rotId;
        w[sbe_pkg::ST_CFGVALID] = st.cfgValid;
        w[sbe_pkg::ST_INFLIGHT +: 4] = st.inFlight;
        w[sbe_pkg::ST_REACHED +: 2] = rch;
        statusWord = w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // counters for the monitor pins

    sbe_event_counter u_cnt0 (
        .clk(clk),
        .rst(rst),
        .clear(s_r.clr0),
        .event_i(perfEvent[0]),
        .limit(s_r.limit0),
        .reached(reached[0])
    );

    sbe_event_counter u_cnt1 (
        .clk(clk),
        .rst(rst),
        .clear(s_r.clr1),
        .event_i(perfEvent[1]),
        .limit(s_r.limit1),
        .reached(reached[1])
    );

    ////////////////////////////////////////////////////////////////////////////
    // next state

    logic reinitObs;
    logic faultEvent;
    logic wrDo;
    logic [31:0] wrOld;
    logic [31:0] wrNew;

    always_comb begin
        s_nxt = s_r;
        s_nxt.busFlush = 1'b0;
        s_nxt.clr0 = 1'b0;
        s_nxt.clr1 = 1'b0;
        wrDo = 1'b0;
        wrOld = 32'h0000_0000;
        wrNew = 32'h0000_0000;

        // axi write, aw and w in either order
        if (s_r.axi.bvalid && axiReq.bready) begin
            s_nxt.axi.bvalid = 1'b0;
        end
        if (s_r.axi.awready && axiReq.awvalid) begin
            s_nxt.awHeld = 1'b1;
            s_nxt.awAddr = axiReq.awaddr;
        end
        if (s_r.axi.wready && axiReq.wvalid) begin
            s_nxt.wHeld = 1'b1;
            s_nxt.wData = axiReq.wdata;
            s_nxt.wStrb = axiReq.wstrb;
        end
        if (s_r.awHeld && s_r.wHeld && !s_r.axi.bvalid) begin
            wrDo = 1'b1;
            s_nxt.awHeld = 1'b0;
            s_nxt.wHeld = 1'b0;
            s_nxt.axi.bvalid = 1'b1;
            s_nxt.axi.bresp = addrOk(s_r.awAddr) ? sbe_pkg::RESP_OKAY : sbe_pkg::RESP_SLVERR;
        end
        if (wrDo) begin
            case (s_r.awAddr)
                sbe_pkg::ADDR_CTRL: begin
                    wrOld = {29'h0, s_r.ctrl};
                    wrNew = mergeBytes(wrOld, s_r.wData, s_r.wStrb);
                    s_nxt.ctrl = wrNew[2:0];
                end
                sbe_pkg::ADDR_STATUS: begin
                    // write one to clear; a same-cycle set below wins
                    wrNew = mergeBytes(32'h0000_0000, s_r.wData, s_r.wStrb);
                    if (wrNew[sbe_pkg::ST_INTERNAL]) s_nxt.internalSeen = 1'b0;
                    if (wrNew[sbe_pkg::ST_FAULT]) s_nxt.faultSent = 1'b0;
                    if (wrNew[sbe_pkg::ST_REINIT]) s_nxt.reinitSeen = 1'b0;
                end
                sbe_pkg::ADDR_LIMIT0: begin
                    wrOld = {16'h0000, s_r.limit0};
                    wrNew = mergeBytes(wrOld, s_r.wData, s_r.wStrb);
                    s_nxt.limit0 = wrNew[15:0];
                    s_nxt.clr0 = 1'b1;
                end
                sbe_pkg::ADDR_LIMIT1: begin
                    wrOld = {16'h0000, s_r.limit1};
                    wrNew = mergeBytes(wrOld, s_r.wData, s_r.wStrb);
                    s_nxt.limit1 = wrNew[15:0];
                    s_nxt.clr1 = 1'b1;
                end
                default: begin
                    wrNew = 32'h0000_0000;
                end
            endcase
        end
        s_nxt.axi.awready = !s_nxt.awHeld;
        s_nxt.axi.wready = !s_nxt.wHeld;

        // axi read, answer one cycle after ar
        if (s_r.axi.rvalid && axiReq.rready) begin
            s_nxt.axi.rvalid = 1'b0;
        end
        if (s_r.axi.arready && axiReq.arvalid) begin
            s_nxt.axi.rvalid = 1'b1;
            s_nxt.axi.rresp = addrOk(axiReq.araddr) ? sbe_pkg::RESP_OKAY : sbe_pkg::RESP_SLVERR;
            case (axiReq.araddr)
                sbe_pkg::ADDR_CFG: s_nxt.axi.rdata = {24'h000000, s_r.strap};
                sbe_pkg::ADDR_CTRL: s_nxt.axi.rdata = {29'h0, s_r.ctrl};
                sbe_pkg::ADDR_STATUS: s_nxt.axi.rdata = statusWord(s_r, reached);
                sbe_pkg::ADDR_LIMIT0: s_nxt.axi.rdata = {16'h0000, s_r.limit0};
                sbe_pkg::ADDR_LIMIT1: s_nxt.axi.rdata = {16'h0000, s_r.limit1};
                default: s_nxt.axi.rdata = 32'h0000_0000;
            endcase
        end
        s_nxt.axi.arready = !s_nxt.axi.rvalid;

        // power-on options latched at bus reset release
        s_nxt.rstPrev = busResetN;
        if (busResetN && !s_r.rstPrev) begin
            s_nxt.strap = addrLines;
            s_nxt.cfgValid = 1'b1;
            s_nxt.rotId = addrLines.agentId;
        end

        // the incoming fault line is deliberately never read

        // pins sampled each edge, active low
        s_nxt.prioSeen = !priorityBusRequestNIn;
        reinitObs = s_r.cfgValid && s_r.strap.reinitObserve && !busReinitNIn;

        // stall: drive on even edges, sample on odd ones
        s_nxt.phase = !s_r.phase;
        if (!s_r.phase) begin
            s_nxt.stallPad.oe = s_r.cfgValid && (notReady || s_r.ctrl[sbe_pkg::CTRL_STALL]);
        end else begin
            s_nxt.stallSeen = !blockNextRequestNIn;
        end

        // fault: straps pick which errors drive it
        faultEvent = s_r.cfgValid && s_r.strap.faultEn && (
            (internalErr && s_r.strap.faultInternal) ||
            (initiatorErr && (s_r.strap.faultInitiator || s_r.strap.faultAny)) ||
            (observedErr && s_r.strap.faultAny));
        if (s_r.faultCnt != 4'h0) begin
            s_nxt.faultCnt = s_r.faultCnt - 4'h1;
        end
        if (faultEvent) begin
            s_nxt.faultCnt = sbe_pkg::FAULT_HOLD_CYC;
            s_nxt.faultSent = 1'b1;
        end

        // internal fault pin stays asserted until reset
        if (internalErr) begin
            s_nxt.intFaultPad.oe = 1'b1;
            s_nxt.internalSeen = 1'b1;
        end

        // own reinit drive; its counter survives the reinit it causes
        if (s_r.reinitCnt != 4'h0) begin
            s_nxt.reinitCnt = s_r.reinitCnt - 4'h1;
        end
        if (s_r.cfgValid && s_r.strap.reinitDrive && unreliable) begin
            s_nxt.reinitCnt = sbe_pkg::REINIT_HOLD_CYC;
        end
        s_nxt.reinitPad.oe = (s_nxt.reinitCnt != 4'h0);

        // arbitration id and transaction bookkeeping
        if (arbRotate) begin
            s_nxt.rotId = s_r.rotId + 2'h1;
        end
        if (txnStart && !txnDone) begin
            s_nxt.inFlight = s_r.inFlight + 4'h1;
        end else if (txnDone && !txnStart && s_r.inFlight != 4'h0) begin
            s_nxt.inFlight = s_r.inFlight - 4'h1;
        end

        // grant only with no stall or reinit, and no priority unless locked
        s_nxt.reqGrant = s_r.cfgValid && reqPending && !s_r.stallSeen &&
            (!s_r.prioSeen || reqLocked) && !reinitObs;

        // seen reinit: bus side idle, registers kept
        if (reinitObs) begin
            s_nxt.phase = 1'b0;
            s_nxt.stallPad.oe = 1'b0;
            s_nxt.stallSeen = 1'b0;
            s_nxt.faultCnt = 4'h0;
            s_nxt.busFlush = 1'b1;
            s_nxt.rotId = s_r.strap.agentId;
            s_nxt.inFlight = 4'h0;
            s_nxt.reinitSeen = 1'b1;
            s_nxt.reqGrant = 1'b0;
        end

        // bus held in reset: no fault, reinit or stall drive, no grant
        if (!busResetN) begin
            s_nxt.cfgValid = 1'b0;
            s_nxt.stallPad.oe = 1'b0;
            s_nxt.faultCnt = 4'h0;
            s_nxt.reinitCnt = 4'h0;
            s_nxt.reinitPad.oe = 1'b0;
            s_nxt.inFlight = 4'h0;
            s_nxt.reqGrant = 1'b0;
        end
        s_nxt.faultPad.oe = (s_nxt.faultCnt != 4'h0);

        // breakpoint and monitor pins
        s_nxt.breakPad.oe = breakHit;
        s_nxt.monitorPad.oe[0] = s_r.ctrl[sbe_pkg::CTRL_MONSEL0] ? reached[0] : breakHit[0];
        s_nxt.monitorPad.oe[1] = s_r.ctrl[sbe_pkg::CTRL_MONSEL1] ? reached[1] : breakHit[1];

        // open-drain, value always low
        s_nxt.faultPad.o = 1'b0;
        s_nxt.reinitPad.o = 1'b0;
        s_nxt.stallPad.o = 1'b0;
        s_nxt.intFaultPad.o = 1'b0;
        s_nxt.breakPad.o = 2'h0;
        s_nxt.monitorPad.o = 2'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
            s_r.ctrl <= sbe_pkg::CTRL_RST;
            s_r.limit0 <= sbe_pkg::LIMIT_RST;
            s_r.limit1 <= sbe_pkg::LIMIT_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs straight from flops

    assign axiRsp = s_r.axi;
    assign busFaultNPad = s_r.faultPad;
    assign busReinitNPad = s_r.reinitPad;
    assign blockNextRequestNPad = s_r.stallPad;
    assign internalFaultNPad = s_r.intFaultPad;
    assign breakStatusNPad = s_r.breakPad;
    assign breakMonitorNPad = s_r.monitorPad;
    assign reqGrant = s_r.reqGrant;
    assign busFlush = s_r.busFlush;
    assign rotId = s_r.rotId;

endmodule

// File: bench/sbe_bus_ctrl_props.sv
/*
 * pin checker for the bus control block.
 * assumes binding to its ports.
 */
`timescale 1ns/1ps
module sbe_bus_ctrl_props (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // bus reset and options
    input wire logic busResetN,
    input wire sbe_pkg::sbe_strap_s addrLines,
    // bus lines
    input wire sbe_pkg::sbe_pad_s busFaultNPad,
    input wire sbe_pkg::sbe_pad_s busReinitNPad,
    input wire logic blockNextRequestNIn,
    input wire sbe_pkg::sbe_pad_s blockNextRequestNPad,
    input wire logic priorityBusRequestNIn,
    input wire sbe_pkg::sbe_pad_s internalFaultNPad,
    // core side
    input wire logic internalErr,
    input wire logic unreliable,
    input wire logic reqLocked,
    input wire logic reqGrant,
    input wire logic busFlush,
    input wire logic [1:0] rotId
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////
    // straps trusted 3 cycles after bus reset release
    logic [1:0] up;
    sbe_pkg::sbe_strap_s cfg;
    wire ok = up == 2'h3;
    always_ff @(posedge clk) begin
        up <= (rst || !busResetN) ? 2'h0 : up + 2'(!ok);
        if (busResetN && up == 2'h0) begin
            cfg <= addrLines;
        end
    end
    sequence s_fault_cause;
        internalErr && ok && cfg.faultEn && cfg.faultInternal;
    endsequence
    sequence s_fault_drive;
        (busFaultNPad.oe && internalFaultNPad.oe) [*3];
    endsequence
    sequence s_stall_seen;
        !blockNextRequestNIn [*2];
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    a_open_drain: assert property (!(busFaultNPad.o | busReinitNPad.o | blockNextRequestNPad.o))
        else $error("pad drives high");
    a_quiet_bus: assert property (!busResetN |=> !reqGrant && !busFaultNPad.oe && !busReinitNPad.oe)
        else $error("drive in bus reset");
    a_fault_internal: assert property (s_fault_cause |=> s_fault_drive)
        else $error("fault pins idle");
    a_reinit_drive: assert property (unreliable && ok && cfg.reinitDrive |=> busReinitNPad.oe [*3])
        else $error("reinit not driven");
    a_reinit_deaf: assert property (ok && !cfg.reinitObserve |-> !busFlush)
        else $error("reinit not ignored");
    a_flush_state: assert property (busFlush |-> !reqGrant && rotId == cfg.agentId)
        else $error("flush left state");
    a_stall_block: assert property (s_stall_seen |-> ##2 !reqGrant)
        else $error("grant in stall");
    a_prio_block: assert property (!priorityBusRequestNIn ##1 !reqLocked |=> !reqGrant)
        else $error("grant in priority");
    a_stall_phase: assert property (ok && !busFlush && $changed(blockNextRequestNPad.oe)
        |=> $stable(blockNextRequestNPad.oe)) else $error("stall drive off phase");
endmodule

// File: bench/sbe_far_agents.sv
/*
 * far agents: fault, reinit, stall drivers, priority agent.
 * assumes every open-drain line has a pull-up, so a released line reads high.
 */
`timescale 1ns/1ps
module sbe_far_agents (
    // clock
    input wire logic clk,
    // device pads
    input wire sbe_pkg::sbe_pad_s faultPad,
    input wire sbe_pkg::sbe_pad_s reinitPad,
    input wire sbe_pkg::sbe_pad_s stallPad,
    // scenario commands
    input wire logic faultCmd,
    input wire logic reinitCmd,
    input wire logic stallCmd,
    input wire logic prioGo,
    // resolved lines
    output logic faultN,
    output logic reinitN,
    output logic stallN,
    output logic prioN
);
    logic phase_r = 1'b0;
    logic stallDrv_r = 1'b0;
    logic reinitDrv_r = 1'b0;
    logic [3:0] prioLeft_r = 4'h0;
    always @(posedge clk) begin
        phase_r <= !phase_r;
        // stall moves on even edges only, so drivers never cross
        if (!phase_r) stallDrv_r <= stallCmd;
        reinitDrv_r <= reinitCmd;
        // held for eight clocks
        prioLeft_r <= prioGo ? 4'h8 : prioLeft_r - 4'(prioLeft_r != 4'h0);
    end
    assign faultN = !(faultPad.oe || faultCmd);
    assign reinitN = !(reinitPad.oe || reinitDrv_r);
    assign stallN = !(stallPad.oe || stallDrv_r);
    assign prioN = prioLeft_r == 4'h0;
endmodule

// File: bench/sbe_bus_ctrl_tb.sv
/*
 * self-checking bench for the bus control block.
 * assumes the far agent model and a bound pin checker.
 */
`timescale 1ns/1ps
bind sbe_bus_ctrl sbe_bus_ctrl_props sbe_bus_ctrl_props_inst (.clk, .rst, .busResetN, .addrLines, .busFaultNPad,
    .busReinitNPad, .blockNextRequestNIn, .blockNextRequestNPad, .priorityBusRequestNIn, .internalFaultNPad,
    .internalErr, .unreliable, .reqLocked, .reqGrant, .busFlush, .rotId);
module sbe_bus_ctrl_tb;
    logic clk, rst, busResetN, internalErr, unreliable, notReady, reqPending, reqLocked, arbRotate;
    logic faultCmd, reinitCmd, stallCmd, prioGo, faultN, reinitN, stallN, prioN, reqGrant, busFlush;
    logic [1:0] breakHit, perfEvent, rotId;
    logic [31:0] rng, flushes, f0;
    logic [31:0] q[$];
    int failures, tests_run;
    sbe_pkg::sbe_axi_req_s req;
    sbe_pkg::sbe_axi_rsp_s rsp;
    sbe_pkg::sbe_strap_s straps;
    sbe_pkg::sbe_pad_s fPad, rPad, sPad, iPad;
    sbe_pkg::sbe_pad2_s bPad, mPad;
    sbe_bus_ctrl sbe_bus_ctrl_inst (.clk, .rst, .axiReq(req), .axiRsp(rsp), .busResetN, .addrLines(straps),
        .busFaultNIn(faultN), .busFaultNPad(fPad), .busReinitNIn(reinitN), .busReinitNPad(rPad),
        .blockNextRequestNIn(stallN), .blockNextRequestNPad(sPad), .priorityBusRequestNIn(prioN),
        .internalFaultNPad(iPad), .breakStatusNPad(bPad), .breakMonitorNPad(mPad), .internalErr,
        .initiatorErr(1'b0), .observedErr(1'b0), .unreliable, .notReady, .breakHit, .perfEvent, .reqPending,
        .reqLocked, .arbRotate, .txnStart(1'b0), .txnDone(1'b0), .reqGrant, .busFlush, .rotId);
    sbe_far_agents sbe_far_agents_inst (.clk, .faultPad(fPad), .reinitPad(rPad), .stallPad(sPad), .faultCmd,
        .reinitCmd, .stallCmd, .prioGo, .faultN, .reinitN, .stallN, .prioN);
    initial begin
        clk = 1'b0;
        forever #25 clk = !clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (e !== s) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic test_done;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // leading edge: no strobe drop and raise in one step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do begin
            @(posedge clk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (req.awvalid && !rsp.awready || req.wvalid && !rsp.wready);
        do @(posedge clk); while (!rsp.bvalid);
        chk("bresp", 32'(a > sbe_pkg::ADDR_LIMIT1 ? sbe_pkg::RESP_SLVERR : sbe_pkg::RESP_OKAY), 32'(rsp.bresp));
        req.bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        q.push_back(e);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do @(posedge clk); while (!rsp.arready);
        req.arvalid <= 1'b0;
        do @(posedge clk); while (!rsp.rvalid);
        req.rready <= 1'b0;
    endtask
    always @(posedge clk) begin
        if (rsp.rvalid && req.rready && q.size() > 0) chk("rdata", q.pop_front(), rsp.rdata);
        flushes <= rst ? 32'h0 : flushes + 32'(busFlush);
    end
    // ~160 cycles needed, wide margin
    initial begin
        #2000000;
        failures++;
        test_done;
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst, reqPending, straps, rng} = {2'h3, 8'hbf, 32'h16da};
        {busResetN, internalErr, unreliable, notReady, reqLocked, arbRotate} = 6'h0;
        {faultCmd, reinitCmd, stallCmd, prioGo, breakHit, perfEvent} = 8'h0;
        {req, failures, tests_run} = '0;
        cyc(12);
        rst <= 1'b0;
        cyc(2);
        busResetN <= 1'b1;
        cyc(4);
        rd(sbe_pkg::ADDR_CFG, 32'hbf);
        rd(sbe_pkg::ADDR_STATUS, 32'hc0);
        rd(sbe_pkg::ADDR_LIMIT1, 32'hffff);
        wr(8'h14, 32'h5);
        rd(8'h14, 32'h0);
        wr(sbe_pkg::ADDR_CTRL, 32'h6);
        rd(sbe_pkg::ADDR_CTRL, 32'h6);
        for (int i = 0; i < 16; i++) begin
            rng = xs(rng);
            breakHit <= rng[1:0];
            cyc(2);
            chk("break", 32'(rng[1:0]), 32'(bPad.oe));
            chk("monitor", 32'h0, 32'(mPad.oe));
        end
        wr(sbe_pkg::ADDR_LIMIT0, 32'h3);
        for (int i = 1; i <= 3; i++) begin
            perfEvent <= 2'h1;
            cyc(1);
            perfEvent <= 2'h0;
            cyc(3);
            chk("reached", 32'(i == 3), 32'(mPad.oe[0]));
        end
        faultCmd <= 1'b1;
        internalErr <= 1'b1;
        cyc(1);
        internalErr <= 1'b0;
        cyc(1);
        chk("faultOe", 32'h1, 32'(fPad.oe && iPad.oe));
        cyc(3);
        chk("faultOe", 32'h0, 32'(fPad.oe));
        faultCmd <= 1'b0;
        rd(sbe_pkg::ADDR_STATUS, 32'h10c3);
        arbRotate <= 1'b1;
        cyc(1);
        {arbRotate, unreliable} <= 2'h1;
        cyc(1);
        unreliable <= 1'b0;
        cyc(1);
        chk("reinitOe", 32'h1, 32'(rPad.oe));
        cyc(6);
        chk("rotId", 32'h2, 32'(rotId));
        chk("flushSeen", 32'h1, 32'(flushes != 32'h0));
        notReady <= 1'b1;
        cyc(4);
        chk("stallOe", 32'h1, 32'(sPad.oe));
        chk("grant", 32'h0, 32'(reqGrant));
        stallCmd <= 1'b1;
        cyc(2);
        notReady <= 1'b0;
        cyc(4);
        chk("grant", 32'h0, 32'(reqGrant));
        stallCmd <= 1'b0;
        cyc(6);
        chk("grant", 32'h1, 32'(reqGrant));
        prioGo <= 1'b1;
        cyc(1);
        prioGo <= 1'b0;
        cyc(3);
        chk("grant", 32'h0, 32'(reqGrant));
        reqLocked <= 1'b1;
        cyc(2);
        chk("grant", 32'h1, 32'(reqGrant));
        reqLocked <= 1'b0;
        cyc(8);
        chk("grant", 32'h1, 32'(reqGrant));
        {straps, busResetN} <= 9'h100;
        cyc(3);
        busResetN <= 1'b1;
        cyc(4);
        rd(sbe_pkg::ADDR_CFG, 32'h80);
        f0 = flushes;
        internalErr <= 1'b1;
        cyc(1);
        internalErr <= 1'b0;
        cyc(2);
        chk("faultOe", 32'h0, 32'(fPad.oe));
        reinitCmd <= 1'b1;
        cyc(2);
        reinitCmd <= 1'b0;
        cyc(3);
        chk("flushes", f0, flushes);
        test_done;
    end
endmodule
